/* File: verilog/tfq_pkg.sv */
// Shared constants and types for the temperature alarm and fault queue block
package tfq_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [2:0] IDX_TEMP = 3'h0;
  localparam logic [2:0] IDX_CFG = 3'h1;
  localparam logic [2:0] IDX_TLOW = 3'h2;
  localparam logic [2:0] IDX_THIGH = 3'h3;
  localparam logic [2:0] IDX_STAT = 3'h4;
  localparam int unsigned IDX_LSB = 2;
  localparam int unsigned IDX_MSB = 4;

  // Values after power-up or reset; general-call reset reloads only CFG_RESET
  localparam logic [15:0] TEMP_RESET = 16'h0000;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [15:0] TLOW_RESET = 16'h4b00;
  localparam logic [15:0] THIGH_RESET = 16'h5000;
  localparam logic [15:0] CFG_WMASK = 16'h007f;

  // Configuration field positions (low byte of the configuration word)
  localparam int unsigned CFG_SD_POS = 0;
  localparam int unsigned CFG_MODE_POS = 1;
  localparam int unsigned CFG_POL_POS = 2;
  localparam int unsigned CFG_FQ_POS = 3;
  localparam int unsigned CFG_RES_POS = 5;

  // Status word field positions
  localparam int unsigned STAT_ALARM_POS = 0;
  localparam int unsigned STAT_CNT_POS = 1;
  localparam int unsigned STAT_NEXTHI_POS = 4;

  // Fault counter width and queue depths for codes 0..3
  localparam int unsigned CNT_W = 3;
  localparam logic [3:0][2:0] QUEUE_DEPTH = {3'h6, 3'h4, 3'h2, 3'h1};

  // Kept result bits for resolution codes 0..3 (9, 10, 11, 12 bits)
  localparam logic [3:0][15:0] RES_MASK = {16'hfff0, 16'hffe0, 16'hffc0, 16'hff80};

  // Alarm mode bit encoding
  localparam logic MODE_CMP = 1'b0;
  localparam logic MODE_INT = 1'b1;

  // Pin level while reset holds: inactive for the default active-low polarity
  localparam logic ALERT_PIN_RESET = 1'b1;

  // Configuration word, msb first
  typedef struct packed {
    logic [8:0] rsvd;
    logic [1:0] res;
    logic [1:0] fq;
    logic alarm_polarity_bit;
    logic mode;
    logic shutdown;
  } tfq_cfg_t;

  // One converted reading from the converter
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } tfq_conv_t;

endpackage

/* File: verilog/tfq_fault_count.sv */
// Consecutive fault counter with queue-depth compare
`timescale 1ns/1ps
module tfq_fault_count #(
  parameter int unsigned CW = 3
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic sample,
  input wire logic fault,
  input wire logic clear,
  input wire logic [CW-1:0] depth,
  output logic [CW-1:0] count,
  output logic valid
);

  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;
  logic at_top;

  // Saturate so a long run of faults never wraps back below the depth
  assign at_top = (count_q == {CW{1'b1}});
  assign count_d = at_top ? count_q : count_q + {{(CW-1){1'b0}}, 1'b1};

  // Valid fault is judged on the incremented count
  assign valid = sample & fault & (count_d >= depth);
  assign count = count_q;

  // Count faults, clear on any non-fault reading
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_q <= '0;
    end else if (ce) begin
      if (clear) begin
        count_q <= '0;
      end else if (sample && fault) begin
        count_q <= count_d;
      end else if (sample) begin
        count_q <= '0;
      end
    end
  end

  cnt_incr_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && sample && fault && !clear && !at_top |=> count_q == $past(count_q) + 1'b1)
    else $error("fault counter did not step on a fault");

  cnt_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && sample && !fault |=> count_q == '0)
    else $error("fault counter not cleared by a clean reading");

endmodule

/* File: verilog/tfq_alarm.sv */
// Temperature result store, limit compare, fault queue and alarm pin with AHB-Lite registers
//
// The address map and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps
module tfq_alarm (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire tfq_pkg::tfq_conv_t conv,
  input wire logic gcall_reset,
  input wire logic ara_reply,
  output logic conv_run,
  output logic [1:0] conv_res,
  output logic alert_pin
);

  logic dp_q;
  logic dp_wr_q;
  logic dp_map_q;
  logic [2:0] dp_idx_q;
  logic wr_done;
  logic rd_done;
  tfq_pkg::tfq_cfg_t cfg_q;
  logic [15:0] temp_q;
  logic [15:0] tlow_q;
  logic [15:0] thigh_q;
  logic cmp_pend_q;
  logic alarm_q;
  logic next_hi_q;
  logic alert_pin_q;
  logic hi_fault;
  logic lo_fault;
  logic any_fault;
  logic valid_evt;
  logic sd_enter;
  logic int_clear;
  logic [tfq_pkg::CNT_W-1:0] fault_cnt;
  logic [2:0] depth;

  // Address phase capture; hsize is accepted as given, only whole words are expected
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_q <= 1'b0;
      dp_wr_q <= 1'b0;
      dp_map_q <= 1'b0;
      dp_idx_q <= 3'h0;
    end else if (ce) begin
      dp_q <= hsel & htrans[1] & hready;
      dp_wr_q <= hwrite;
      dp_idx_q <= haddr[tfq_pkg::IDX_MSB:tfq_pkg::IDX_LSB];
      dp_map_q <= (haddr[31:5] == 27'h0) &&
                  (haddr[tfq_pkg::IDX_MSB:tfq_pkg::IDX_LSB] <= tfq_pkg::IDX_STAT);
    end
  end

  // A data phase completes only on an enabled edge, so a frozen block stalls the bus
  assign hreadyout = ~dp_q | ce;
  assign hresp = 1'b0;
  assign wr_done = ce & dp_q & dp_wr_q & dp_map_q;
  assign rd_done = ce & dp_q & ~dp_wr_q & dp_map_q;

  // Read mux over flip-flop held registers; unmapped reads return zero
  always_comb begin
    hrdata = 32'h0000_0000;
    if (dp_q && dp_map_q) begin
      case (dp_idx_q)
        tfq_pkg::IDX_TEMP: hrdata = {16'h0000, temp_q};
        tfq_pkg::IDX_CFG: hrdata = {16'h0000, cfg_q};
        tfq_pkg::IDX_TLOW: hrdata = {16'h0000, tlow_q};
        tfq_pkg::IDX_THIGH: hrdata = {16'h0000, thigh_q};
        tfq_pkg::IDX_STAT: begin
          hrdata[tfq_pkg::STAT_ALARM_POS] = alarm_q;
          hrdata[tfq_pkg::STAT_CNT_POS +: tfq_pkg::CNT_W] = fault_cnt;
          hrdata[tfq_pkg::STAT_NEXTHI_POS] = next_hi_q;
        end
        default: hrdata = 32'h0000_0000;
      endcase
    end
  end

  // Configuration; general-call reset returns it to defaults, comparator mode included
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_q <= tfq_pkg::CFG_RESET;
    end else if (ce) begin
      if (gcall_reset) begin
        cfg_q <= tfq_pkg::CFG_RESET;
      end else if (wr_done && dp_idx_q == tfq_pkg::IDX_CFG) begin
        cfg_q <= tfq_pkg::tfq_cfg_t'(hwdata[15:0] & tfq_pkg::CFG_WMASK);
      end
    end
  end

  // Limits keep their values across general-call reset; configuration, alarm state and fault counter revert
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tlow_q <= tfq_pkg::TLOW_RESET;
      thigh_q <= tfq_pkg::THIGH_RESET;
    end else if (ce && wr_done) begin
      if (dp_idx_q == tfq_pkg::IDX_TLOW) begin
        tlow_q <= hwdata[15:0];
      end
      if (dp_idx_q == tfq_pkg::IDX_THIGH) begin
        thigh_q <= hwdata[15:0];
      end
    end
  end

  // Result store; the converter idles in shutdown, so no result lands then
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      temp_q <= tfq_pkg::TEMP_RESET;
      cmp_pend_q <= 1'b0;
    end else if (ce) begin
      cmp_pend_q <= conv.valid & ~cfg_q.shutdown;
      if (conv.valid && !cfg_q.shutdown) begin
        temp_q <= conv.data & tfq_pkg::RES_MASK[cfg_q.res];
      end
    end
  end

  assign conv_run = ~cfg_q.shutdown;
  assign conv_res = cfg_q.res;

  // Limit compare on the stored result; a wrongly ordered limit pair favours the high side
  assign hi_fault = $signed(temp_q) >= $signed(thigh_q);
  assign lo_fault = $signed(temp_q) <= $signed(tlow_q);
  assign any_fault = hi_fault | lo_fault;
  assign depth = tfq_pkg::QUEUE_DEPTH[cfg_q.fq];

  // Counter state survives shutdown; reset, general-call reset and a clean reading clear it
  tfq_fault_count #(
    .CW(tfq_pkg::CNT_W)
  ) u_count (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .sample(cmp_pend_q),
    .fault(any_fault),
    .clear(gcall_reset),
    .depth(depth),
    .count(fault_cnt),
    .valid(valid_evt)
  );

  // Interrupt-mode clear sources: any register read, alert reply, entering shutdown
  assign sd_enter = wr_done && dp_idx_q == tfq_pkg::IDX_CFG &&
                    hwdata[tfq_pkg::CFG_SD_POS] && !cfg_q.shutdown;
  assign int_clear = (cfg_q.mode == tfq_pkg::MODE_INT) & (rd_done | ara_reply | sd_enter);

  // Alarm state; a new event wins over a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm_q <= 1'b0;
      next_hi_q <= 1'b1;
    end else if (ce) begin
      if (gcall_reset) begin
        alarm_q <= 1'b0;
        next_hi_q <= 1'b1;
      end else if (valid_evt && cfg_q.mode == tfq_pkg::MODE_CMP) begin
        alarm_q <= hi_fault;
        next_hi_q <= ~hi_fault;
      end else if (valid_evt && hi_fault == next_hi_q) begin
        alarm_q <= 1'b1;
        next_hi_q <= ~next_hi_q;
      end else if (int_clear) begin
        alarm_q <= 1'b0;
      end
    end
  end

  // Pin follows alarm and polarity one edge later, from a flip-flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alert_pin_q <= tfq_pkg::ALERT_PIN_RESET;
    end else if (ce) begin
      alert_pin_q <= cfg_q.alarm_polarity_bit ? alarm_q : ~alarm_q;
    end
  end

  assign alert_pin = alert_pin_q;

  temp_store_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && conv.valid && !cfg_q.shutdown |=>
      temp_q == ($past(conv.data) & tfq_pkg::RES_MASK[$past(cfg_q.res)]))
    else $error("result not stored after conversion");

  gcall_default_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && gcall_reset |=> cfg_q == tfq_pkg::CFG_RESET && !alarm_q && cfg_q.res == 2'h0)
    else $error("general-call reset left state behind");

  cmp_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && !gcall_reset && valid_evt && hi_fault && cfg_q.mode == tfq_pkg::MODE_CMP |=> alarm_q)
    else $error("comparator high fault did not raise alarm");

  cmp_release_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && !gcall_reset && valid_evt && !hi_fault && cfg_q.mode == tfq_pkg::MODE_CMP
      |=> !alarm_q)
    else $error("comparator low fault did not release alarm");

  cmp_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && !gcall_reset && !valid_evt && cfg_q.mode == tfq_pkg::MODE_CMP |=> $stable(alarm_q))
    else $error("comparator alarm changed without a valid fault");

  int_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && int_clear && !valid_evt |=> !alarm_q)
    else $error("interrupt alarm not cleared");

  int_order_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && !alarm_q && valid_evt && cfg_q.mode == tfq_pkg::MODE_INT && hi_fault != next_hi_q
      |=> !alarm_q)
    else $error("interrupt event out of order raised alarm");

  pin_pol_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce |=> alert_pin == ($past(cfg_q.alarm_polarity_bit) ? $past(alarm_q) : !$past(alarm_q)))
    else $error("alarm pin polarity wrong");

  queue_depth_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && cmp_pend_q && any_fault && fault_cnt != '1 && fault_cnt + 1'b1 < depth
      |-> !valid_evt)
    else $error("valid fault before queue depth");

  shut_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && sd_enter && !cmp_pend_q && !gcall_reset |=> $stable(fault_cnt))
    else $error("shutdown changed the fault counter");

  freeze_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !ce |=> $stable(alarm_q) && $stable(cfg_q) && $stable(temp_q))
    else $error("state moved with clock enable low");

  // Store, configuration and alarm sequencing; a saturated counter must not trip these
  cmp_pend_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && conv.valid && !cfg_q.shutdown |=> cmp_pend_q)
    else $error("stored result not compared");

  sd_store_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && cfg_q.shutdown |=> $stable(temp_q))
    else $error("result changed during shutdown");

  cfg_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && wr_done && dp_idx_q == tfq_pkg::IDX_CFG && !gcall_reset
      |=> cfg_q == ($past(hwdata[15:0]) & tfq_pkg::CFG_WMASK))
    else $error("configuration write not applied");

  gcall_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && gcall_reset |=> fault_cnt == '0 && next_hi_q)
    else $error("general-call reset left counter or order state");

  limit_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && gcall_reset && !wr_done |=> $stable(tlow_q) && $stable(thigh_q))
    else $error("general-call reset changed a limit");

  int_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && !gcall_reset && alarm_q && cfg_q.mode == tfq_pkg::MODE_INT && !int_clear
      |=> alarm_q)
    else $error("interrupt alarm dropped without a clear");

  int_raise_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && valid_evt && !gcall_reset && cfg_q.mode == tfq_pkg::MODE_INT
      && hi_fault == next_hi_q |=> alarm_q)
    else $error("expected interrupt event did not raise alarm");

  next_flip_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && valid_evt && !gcall_reset && (cfg_q.mode == tfq_pkg::MODE_CMP || hi_fault == next_hi_q)
      |=> next_hi_q == !$past(hi_fault))
    else $error("expected event side did not alternate");

  rd_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && rd_done && !valid_evt && !gcall_reset && cfg_q.mode == tfq_pkg::MODE_CMP
      |=> $stable(alarm_q))
    else $error("comparator alarm changed on a register read");

endmodule

/* File: verification/tfq_conv_model.sv */
// Behavioural converter model feeding readings into the alarm block
`timescale 1ns/1ps
module tfq_conv_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run,
  input wire logic req,
  input wire logic [15:0] temp,
  output tfq_pkg::tfq_conv_t conv
);
  // Low nibble set so resolution masking shows; idle data toggles so stale data never looks held
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv <= '0;
    end else begin
      conv.valid <= req & run;
      conv.data <= (req & run) ? {temp[15:4], 4'hf} : ~conv.data;
    end
  end
endmodule

/* File: verification/test_tfq_alarm.sv */
// Self-checking bench for the temperature alarm block
`timescale 1ns/1ps
module test_tfq_alarm;
  localparam logic [15:0] HOT = 16'h5000;
  localparam logic [15:0] COLD = 16'h4b00;
  localparam logic [15:0] MID = 16'h4e00;
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic ce = 1'h1;
  logic hwrite = 1'h0;
  logic req = 1'h0;
  logic gcall = 1'h0;
  logic ara = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [15:0] temp = 16'h0;
  logic hreadyout;
  logic hresp;
  logic conv_run;
  logic alert_pin;
  logic [1:0] conv_res;
  tfq_pkg::tfq_conv_t conv;
  logic [15:0] rv [6] = '{16'h0, 16'h0, 16'h4b00, 16'h5000, 16'h0010, 16'h0};
  int fail_count = 0;
  int cmp_count = 0;

  // Clock at 4 ns
  initial forever #2 hclk = ~hclk;

  tfq_alarm uut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .conv(conv),
    .gcall_reset(gcall), .ara_reply(ara), .conv_run(conv_run), .conv_res(conv_res),
    .alert_pin(alert_pin));
  tfq_conv_model cm (.hclk(hclk), .hresetn(hresetn), .run(conv_run), .req(req),
    .temp(temp), .conv(conv));

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  // One handshake stage; hready and data looked at in the settled half before the edge
  task automatic stage();
    logic r;
    int n;
    n = 0;
    do begin
      @(negedge hclk);
      r = hreadyout;
      rd = hrdata;
      @(posedge hclk);
      n++;
    end while (r !== 1'h1 && n < 50);
    if (r !== 1'h1) begin
      fail_count++;
      $display("BAD %0t bus wait ran out", $time);
      give_verdict();
    end
  endtask

  task automatic bus(input logic w, input logic [2:0] i, input logic [15:0] d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {27'h0, i, 2'h0};
    stage();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= {16'h0, d};
    stage();
  endtask

  // Each reading is spaced far enough for the pin to settle
  task automatic cv(input logic [15:0] t, input int k);
    repeat (k) begin
      temp <= t;
      req <= 1'h1;
      @(posedge hclk);
      req <= 1'h0;
      repeat (4) @(posedge hclk);
    end
  endtask

  task automatic pin(input logic e);
    @(posedge hclk);
    @(negedge hclk);
    chk({31'h0, alert_pin}, {31'h0, e});
    @(posedge hclk);
  endtask

  task automatic t_reset();
    for (int i = 0; i < 6; i++) begin
      bus(1'h0, 3'(i), 16'h0);
      chk(rd, {16'h0, rv[i]});
      chk({31'h0, hresp}, 32'h0);
    end
    pin(1'h1);
    chk({30'h0, conv_res}, 32'h0);
    $display("reset test done");
  endtask

  task automatic t_res();
    for (int r = 0; r < 4; r++) begin
      bus(1'h1, 3'h1, 16'(r << 5));
      cv(16'h1230, 1);
      chk({30'h0, conv_res}, 32'(r));
      bus(1'h0, 3'h0, 16'h0);
      chk(rd, {16'h0, 16'h123f & (16'hffff << (7 - r))});
    end
    $display("resolution test done");
  endtask

  task automatic t_queue();
    int d;
    for (int q = 0; q < 4; q++) begin
      d = (q == 0) ? 1 : 2 * q;
      cv(MID, 1);
      bus(1'h1, 3'h1, 16'(q << 3));
      cv(HOT, d - 1);
      cv(MID, 1);
      cv(HOT, d - 1);
      pin(1'h1);
      cv(HOT, 1);
      pin(1'h0);
      bus(1'h0, 3'h2, 16'h0);
      pin(1'h0);
      cv(MID, 1);
      cv(COLD, d - 1);
      pin(1'h0);
      cv(COLD, 1);
      pin(1'h1);
    end
    $display("queue test done");
  endtask

  task automatic t_pol();
    bus(1'h1, 3'h3, 16'h5000);
    bus(1'h1, 3'h1, 16'h0004);
    pin(1'h0);
    cv(HOT, 1);
    pin(1'h1);
    bus(1'h1, 3'h1, 16'h0005);
    pin(1'h1);
    chk({31'h0, conv_run}, 32'h0);
    bus(1'h0, 3'h4, 16'h0);
    chk(rd, 32'h0000_000f);
    gcall <= 1'h1;
    @(posedge hclk);
    gcall <= 1'h0;
    pin(1'h1);
    bus(1'h0, 3'h1, 16'h0);
    chk(rd, 32'h0);
    $display("polarity test done");
  endtask

  task automatic t_int();
    bus(1'h1, 3'h1, 16'h0002);
    cv(COLD, 1);
    pin(1'h1);
    cv(HOT, 1);
    pin(1'h0);
    bus(1'h0, 3'h0, 16'h0);
    pin(1'h1);
    cv(COLD, 1);
    pin(1'h0);
    bus(1'h1, 3'h1, 16'h0000);
    pin(1'h0);
    cv(MID, 1);
    cv(COLD, 1);
    pin(1'h1);
    bus(1'h1, 3'h1, 16'h0002);
    cv(HOT, 1);
    pin(1'h0);
    ara <= 1'h1;
    @(posedge hclk);
    ara <= 1'h0;
    pin(1'h1);
    $display("interrupt test done");
  endtask

  // A reading offered while the clock enable is low is lost, so the pin must not move
  task automatic t_ce();
    bus(1'h1, 3'h1, 16'h0000);
    ce <= 1'h0;
    cv(HOT, 1);
    ce <= 1'h1;
    pin(1'h1);
    cv(HOT, 1);
    pin(1'h0);
    $display("clock enable test done");
  endtask

  // Reset for six cycles, then the scenarios in turn
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    t_reset();
    t_res();
    t_queue();
    t_pol();
    t_int();
    t_ce();
    give_verdict();
  end
endmodule
